// file: pkg/sfc_pkg.sv
// Purpose: shared constants and carriers of the framed serial port control
// Assumes: 32-bit AHB-Lite register window, 100 MHz clock
// Notes: byte addresses of the four registers are word aligned
package sfc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SFC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SFC_DATA_OFS = 8'h04;
  localparam logic [7:0] SFC_STAT_OFS = 8'h08;
  localparam logic [7:0] SFC_AUX_OFS = 8'h0c;
  localparam logic [31:0] SFC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SFC_CTRL_WMASK = 32'hff83_bfff;
  localparam logic [31:0] SFC_LOCK_MASK = 32'h0081_0000;
  localparam logic [31:0] SFC_AUX_WMASK = 32'h0000_0001;
  localparam logic [31:0] SFC_AUX_RST = 32'h0000_0000;

  // status bit positions
  localparam int SFC_ST_BUSY = 0;
  localparam int SFC_ST_TXFULL = 1;
  localparam int SFC_ST_RXFULL = 2;
  localparam int SFC_ST_FRAME = 3;
  localparam int SFC_ST_GRP_LO = 8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SFC_CLK_NS = 10;
  localparam int SFC_SCK_HALF_NS = 60;
  localparam int SFC_SCK_HALF_CYC =
    (SFC_SCK_HALF_NS + SFC_CLK_NS - 1) / SFC_CLK_NS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic framed_mode_enable;         // 31
    logic frame_sync_direction;       // 30
    logic frame_sync_polarity;        // 29
    logic master_auto_select_enable;  // 28
    logic frame_sync_pulse_width;     // 27
    logic [2:0] frame_pulse_count;    // 26:24
    logic master_clock_select;        // 23
    logic [4:0] rsv_22_18;
    logic frame_edge_select;          // 17
    logic enhanced_buffer_enable;     // 16
    logic module_enable;              // 15
    logic rsv_14;
    logic stop_in_idle;               // 13
    logic serial_out_disable;         // 12
    logic word32_select;              // 11
    logic word16_select;              // 10
    logic input_sample_phase;         // 9
    logic clock_edge_select;          // 8
    logic slave_select_enable;        // 7
    logic clock_polarity_select;      // 6
    logic master_role_select;         // 5
    logic serial_in_disable;          // 4
    logic [1:0] tx_irq_mode;          // 3:2
    logic [1:0] rx_irq_mode;          // 1:0
  } sfc_ctrl_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ss_o;
    logic ss_oe;
  } sfc_pins_t;

  typedef enum logic [1:0] {
    SFC_IDLE = 2'b00,
    SFC_WAIT_SYNC = 2'b01,
    SFC_RUN = 2'b11
  } sfc_state_t;

endpackage : sfc_pkg

// file: rtl/sfc_core.sv
// Purpose: framed serial port control, frame sync and shift engine
// Assumes: AHB-Lite slave, single word transfers; pins sampled on clk
// Notes: pin inputs pass four flops (three stages and the held output) before use
`timescale 1ns/1ps

// ---------------------------------------------------------------
// three-stage input filter
// ---------------------------------------------------------------
module sfc_sync3 (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic d, // raw pin
  output logic q // filtered level
);
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule : sfc_sync3

module sfc_core
  import sfc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // ready out
  output logic hresp, // response
  input wire logic sck_i, // serial clock pin in
  input wire logic sdi_i, // serial data pin in
  input wire logic ss_i, // select pin in
  output sfc_pins_t pins_o // pin outputs and enables
);

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  sfc_ctrl_t ctrl_q;
  logic [31:0] aux_q, hrdata_q, tx_q, rx_q, sh_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic tx_full_q, rx_full_q, loaded_q, samp_q, fpulse_q, sync_seen_q;
  logic [5:0] bitcnt_q;
  logic [4:0] grp_q;
  logic [15:0] div_q;
  logic phase_q, sck_prev_q, sync_prev_q;
  sfc_state_t state_q;
  logic sck_f, sdi_f, ss_f;

  logic ap, rd_data, wr_data;
  assign ap = hsel & htrans[1] & hready;
  assign rd_data = ap & ~hwrite & (haddr[7:0] == SFC_DATA_OFS);
  assign wr_data = wr_q & (addr_q == SFC_DATA_OFS);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce) begin
      wr_q <= ap & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= SFC_CTRL_RST;
      aux_q <= SFC_AUX_RST;
    end else if (ce && wr_q) begin
      if (addr_q == SFC_CTRL_OFS) begin
        // locked bits keep their value while the port runs
        if (ctrl_q.module_enable) begin
          ctrl_q <= (hwdata & SFC_CTRL_WMASK & ~SFC_LOCK_MASK) |
                    (ctrl_q & SFC_LOCK_MASK);
        end else begin
          ctrl_q <= hwdata & SFC_CTRL_WMASK;
        end
      end
      if (addr_q == SFC_AUX_OFS) begin
        aux_q <= hwdata & SFC_AUX_WMASK;
      end
    end
  end

  logic [31:0] stat;
  always_comb begin
    stat = 32'h0000_0000;
    stat[SFC_ST_BUSY] = (state_q != SFC_IDLE) | (bitcnt_q != 6'h00);
    stat[SFC_ST_TXFULL] = tx_full_q;
    stat[SFC_ST_RXFULL] = rx_full_q;
    stat[SFC_ST_FRAME] = fpulse_q;
    stat[SFC_ST_GRP_LO +: 5] = grp_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && ap && !hwrite) begin
      unique case (haddr[7:0])
        SFC_CTRL_OFS: hrdata_q <= ctrl_q;
        SFC_DATA_OFS: hrdata_q <= rx_q;
        SFC_STAT_OFS: hrdata_q <= stat;
        SFC_AUX_OFS: hrdata_q <= aux_q;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // derived modes
  // ---------------------------------------------------------------
  logic on, framed, master, ckp_eff, cke_eff, sel_ok, sync_act;
  logic [5:0] width;
  logic [4:0] grp_mask;
  assign on = ctrl_q.module_enable;
  assign framed = on & ctrl_q.framed_mode_enable;
  assign master = ctrl_q.master_role_select;
  assign ckp_eff = ctrl_q.clock_polarity_select | aux_q[0];
  // edge select has no say once framing is on
  assign cke_eff = ctrl_q.clock_edge_select & ~framed;
  assign width = ctrl_q.word32_select ? 6'd32 :
                 ctrl_q.word16_select ? 6'd16 : 6'd8;
  assign sync_act = (ss_f == ctrl_q.frame_sync_polarity);
  // reserved counts fall back to one pulse per character
  always_comb begin
    grp_mask = 5'h00;
    if (framed && ctrl_q.frame_pulse_count <= 3'h5) begin
      grp_mask = 5'((6'h01 << ctrl_q.frame_pulse_count) - 6'h01);
    end
  end
  // slave gating by select pin, open when framed
  assign sel_ok = framed ? 1'b1 :
                  (~ctrl_q.slave_select_enable | ~ss_f);

  sfc_sync3 u_sck (.clk(clk), .arst_n(arst_n), .ce(ce), .d(sck_i),
                   .q(sck_f));
  sfc_sync3 u_sdi (.clk(clk), .arst_n(arst_n), .ce(ce), .d(sdi_i),
                   .q(sdi_f));
  sfc_sync3 u_ss (.clk(clk), .arst_n(arst_n), .ce(ce), .d(ss_i),
                  .q(ss_f));

  // ---------------------------------------------------------------
  // serial clock edges, generated or detected
  // ---------------------------------------------------------------
  logic tick, lead_e, trail_e, sync_ok, sample_e, shift_e, last_e;
  assign tick = (state_q == SFC_RUN) &&
                (div_q == 16'(SFC_SCK_HALF_CYC - 1));
  // a group waits for its sync when the pulse comes from outside
  assign sync_ok = ~framed | ~ctrl_q.frame_sync_direction |
                   (grp_q != 5'h00) | sync_seen_q;
  always_comb begin
    if (master) begin
      lead_e = tick & ~phase_q;
      trail_e = tick & phase_q;
    end else begin
      lead_e = on & sel_ok & sync_ok & (sck_f != sck_prev_q) &
               (sck_prev_q == ckp_eff);
      trail_e = on & sel_ok & (bitcnt_q != 6'h00) & (sck_f != sck_prev_q) &
                (sck_prev_q != ckp_eff);
    end
  end
  assign sample_e = cke_eff ? lead_e : trail_e;
  assign shift_e = (cke_eff ? trail_e : lead_e) & (bitcnt_q != 6'h00);
  assign last_e = sample_e & (bitcnt_q == width - 6'h01);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_f;
      sync_prev_q <= sync_act;
    end
  end

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  logic start_m, finish_m;
  assign start_m = (state_q == SFC_IDLE) & on & master & tx_full_q;
  // leading-edge sampling has cleared the count by the final trail
  assign finish_m = trail_e & master &
                    (cke_eff ? (bitcnt_q == 6'h00) : last_e);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SFC_IDLE;
    end else if (ce) begin
      unique case (state_q)
        SFC_IDLE: if (start_m) begin
          state_q <= SFC_WAIT_SYNC;
        end
        SFC_WAIT_SYNC: if (!on) begin
          state_q <= SFC_IDLE;
        end else if (sync_ok) begin
          state_q <= SFC_RUN;
        end
        SFC_RUN: if (!on || finish_m) begin
          state_q <= SFC_IDLE;
        end
        default: state_q <= SFC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 16'h0000;
      phase_q <= 1'b0;
    end else if (ce) begin
      if (state_q != SFC_RUN) begin
        div_q <= 16'h0000;
        phase_q <= 1'b0;
      end else if (tick) begin
        div_q <= 16'h0000;
        phase_q <= ~phase_q;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // shift engine and data registers
  // ---------------------------------------------------------------
  logic load_m, load_s, char_start;
  assign load_m = (state_q == SFC_WAIT_SYNC) & sync_ok & on;
  assign load_s = ~master & on & (bitcnt_q == 6'h00) & ~loaded_q &
                  tx_full_q;
  assign char_start = master ? load_m : (lead_e & (bitcnt_q == 6'h00));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 32'h0000_0000;
      samp_q <= 1'b0;
      bitcnt_q <= 6'h00;
      loaded_q <= 1'b0;
    end else if (ce) begin
      if (!on) begin
        bitcnt_q <= 6'h00;
        loaded_q <= 1'b0;
      end else begin
        if (load_m || load_s) begin
          sh_q <= tx_q;
          loaded_q <= 1'b1;
        end else if (shift_e) begin
          sh_q <= {sh_q[30:0], samp_q};
        end
        if (last_e) begin
          bitcnt_q <= 6'h00;
          loaded_q <= 1'b0;
        end else if (sample_e) begin
          samp_q <= sdi_f;
          bitcnt_q <= bitcnt_q + 6'h01;
        end
      end
    end
  end

  // set wins over clear on both data flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= 32'h0000_0000;
      tx_full_q <= 1'b0;
      rx_q <= 32'h0000_0000;
      rx_full_q <= 1'b0;
    end else if (ce) begin
      if (wr_data) begin
        tx_q <= hwdata;
        tx_full_q <= 1'b1;
      end else if (load_m || load_s) begin
        tx_full_q <= 1'b0;
      end
      if (last_e) begin
        rx_q <= ({sh_q[30:0], sdi_f}) & ((32'h1 << width) - 32'h1);
        rx_full_q <= 1'b1;
      end else if (rd_data) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // frame grouping and sync pulse
  // ---------------------------------------------------------------
  logic gen_sync;
  assign gen_sync = framed & ~ctrl_q.frame_sync_direction & master;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grp_q <= 5'h00;
    end else if (ce) begin
      if (!framed) begin
        grp_q <= 5'h00;
      end else if (last_e) begin
        grp_q <= (grp_q + 5'h01) & grp_mask;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_seen_q <= 1'b0;
    end else if (ce) begin
      // armed only as an input: the filter's reset level fakes an edge
      if (framed && ctrl_q.frame_sync_direction && sync_act &&
          !sync_prev_q) begin
        sync_seen_q <= 1'b1;
      end else if (char_start && grp_q == 5'h00) begin
        sync_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fpulse_q <= 1'b0;
    end else if (ce) begin
      if (!gen_sync) begin
        fpulse_q <= 1'b0;
      end else if (load_m && grp_q == 5'h00) begin
        fpulse_q <= 1'b1;
      end else if (ctrl_q.frame_sync_pulse_width ? last_e : trail_e) begin
        fpulse_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic auto_ss;
  assign auto_ss = on & master & ctrl_q.master_auto_select_enable & ~framed;
  always_comb begin
    pins_o.sck_o = ckp_eff ^ phase_q;
    pins_o.sck_oe = on & master;
    pins_o.sdo_o = sh_q[5'(width - 6'h01)];
    pins_o.sdo_oe = on & ~ctrl_q.serial_out_disable & (master | sel_ok);
    if (gen_sync) begin
      pins_o.ss_o = fpulse_q ~^ ctrl_q.frame_sync_polarity;
      pins_o.ss_oe = 1'b1;
    end else if (auto_ss) begin
      pins_o.ss_o = (state_q == SFC_RUN) ~^
                    ctrl_q.frame_sync_polarity;
      pins_o.ss_oe = 1'b1;
    end else begin
      pins_o.ss_o = 1'b1;
      pins_o.ss_oe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_lock_bits_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && wr_q && addr_q == SFC_CTRL_OFS && on)
      |=> ((ctrl_q & SFC_LOCK_MASK) == $past(ctrl_q & SFC_LOCK_MASK)))
    else $error("locked control bits changed while on");

  a_sync_in_tristate: assert property (
    @(posedge clk) disable iff (!arst_n)
    (framed && ctrl_q.frame_sync_direction) |-> !pins_o.ss_oe)
    else $error("select pin driven while sync is an input");

  a_frame_start_pulse: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && gen_sync && load_m && grp_q == 5'h00)
      |=> (fpulse_q && pins_o.ss_o == ctrl_q.frame_sync_polarity))
    else $error("no sync pulse at start of group");

  a_short_pulse_len: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(fpulse_q) && !ctrl_q.frame_sync_pulse_width && ce)
      |-> ##[1:20] !fpulse_q)
    else $error("clock-wide sync pulse too long");

  a_auto_select_lvl: assert property (
    @(posedge clk) disable iff (!arst_n)
    (auto_ss && state_q == SFC_RUN)
      |-> (pins_o.ss_oe && pins_o.ss_o == ctrl_q.frame_sync_polarity))
    else $error("auto select not active during transfer");

  a_idle_clock_lvl: assert property (
    @(posedge clk) disable iff (!arst_n)
    (master && state_q == SFC_IDLE && aux_q[0]) |-> pins_o.sck_o)
    else $error("audio mode idle clock not high");

  a_group_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && framed && last_e && grp_q == grp_mask) |=> (grp_q == 5'h00))
    else $error("frame group did not wrap");

  a_slave_gate: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!master && !framed && ctrl_q.slave_select_enable && ss_f)
      |-> !(lead_e || trail_e))
    else $error("slave shifted while deselected");

  a_unused_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && ap && !hwrite && haddr[7:0] == SFC_CTRL_OFS)
      |=> ((hrdata & ~SFC_CTRL_WMASK) == 32'h0000_0000))
    else $error("unused control bits read non-zero");

  a_no_frame_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!framed) |-> (!fpulse_q && grp_q == 5'h00))
    else $error("framing active while disabled");

endmodule : sfc_core

// file: bench/sfc_peer.sv
// Purpose: serial peer on the far side of the framed port
// Assumes: port is master with idle-low clock, 8-bit characters
// Notes: released data line toggles every cycle between characters
`timescale 1ns/1ps
module sfc_peer
  import sfc_pkg::*;
(
  input wire logic clk, // clock
  input sfc_pins_t pins, // port pin outputs
  output logic sdi, // data to port
  output logic ss, // sync pin to port
  output logic sck // slave clock, stands still
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  int nr = 8;
  int nf = 8;
  logic ps = 1'b0;
  initial begin
    sdi = 1'b0;
    ss = 1'b1;
    sck = 1'b0;
  end
  // new bit on the leading edge, port samples on the trailing one
  always @(posedge clk) begin
    if (pins.sck_o && !ps && nr < 8) begin
      sdi <= tx[7-nr];
      nr <= nr + 1;
    end else if (nr == 8 && nf == 8) begin
      sdi <= ~sdi;
    end
    if (!pins.sck_o && ps && nf < 8) begin
      rx <= {rx[6:0], pins.sdo_o};
      nf <= nf + 1;
    end
    ps <= pins.sck_o;
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    nr = 0;
    nf = 0;
  endtask : load
  // active-low sync pulse of one serial clock period
  task automatic sync();
    ss <= 1'b0;
    repeat (12) @(posedge clk);
    ss <= 1'b1;
  endtask : sync
endmodule : sfc_peer

// file: bench/testbench.sv
// Purpose: self-checking bench of the framed serial port control
// Assumes: one serial peer on the link, 8-bit characters
// Notes: reset is pulsed before each pulse count code
`timescale 1ns/1ps
module testbench;
  import sfc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, hreadyout, hresp, sdi, ss, sck;
  sfc_pins_t pins;
  logic [7:0] lfsr = 8'h1a;
  int errors = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  assign hready = hreadyout;
  sfc_core u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck), .sdi_i(sdi),
    .ss_i(ss), .pins_o(pins));
  sfc_peer u_peer (.clk(clk), .pins(pins), .sdi(sdi), .ss(ss), .sck(sck));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // one single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic rst();
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask : rst

  // one character; ep says whether a generated pulse is due
  task automatic xfer(input bit ep, input bit pw, input bit pol,
                      input bit ext);
    logic [7:0] t, p;
    int act, falls, w, e;
    logic ps;
    t = rnd();
    p = rnd();
    act = 0;
    falls = 0;
    w = 0;
    ps = 1'b0;
    // let the control write settle before looking at the pins
    @(posedge clk);
    u_peer.load(p);
    if (!ext) chk("sync idle", 32'(!pol), 32'(pins.ss_o));
    chk("sync drive", 32'(!ext), 32'(pins.ss_oe));
    bus(1'b1, SFC_DATA_OFS, {24'h0, t});
    if (ext) begin
      repeat (40) @(posedge clk);
      chk("sck held", 32'h0, 32'(pins.sck_o));
      u_peer.sync();
    end
    while (falls < 8 && w < 2000) begin
      @(negedge clk);
      w++;
      if (pins.ss_o === pol && !ext) act++;
      if (ps && !pins.sck_o) falls++;
      ps = pins.sck_o;
    end
    repeat (20) @(posedge clk);
    bus(1'b0, SFC_STAT_OFS, 32'h0);
    chk("status", 32'h4, q & 32'h7);
    bus(1'b0, SFC_DATA_OFS, 32'h0);
    chk("rx data", {24'h0, p}, q);
    chk("tx data", {24'h0, t}, {24'h0, u_peer.rx});
    e = ep ? (pw ? 16 : 2) * SFC_SCK_HALF_CYC : 0;
    if (!ext) chk("pulse", e, (act >= e-3 && act <= e+3) ? e : act);
  endtask : xfer

  initial begin
    int n;
    rst();
    bus(1'b0, SFC_CTRL_OFS, 32'h0);
    chk("ctrl reset", SFC_CTRL_RST, q);
    bus(1'b0, SFC_AUX_OFS, 32'h0);
    chk("aux reset", SFC_AUX_RST, q);
    chk("hresp", 32'h0, 32'(hresp));
    bus(1'b1, SFC_CTRL_OFS, 32'hffff_ffff);
    bus(1'b0, SFC_CTRL_OFS, 32'h0);
    chk("ctrl mask", SFC_CTRL_WMASK, q);
    bus(1'b1, SFC_CTRL_OFS, 32'h0);
    bus(1'b0, SFC_CTRL_OFS, 32'h0);
    chk("ctrl locked", SFC_LOCK_MASK, q);
    bus(1'b1, SFC_CTRL_OFS, 32'h0);
    bus(1'b0, SFC_CTRL_OFS, 32'h0);
    chk("ctrl off", 32'h0, q);
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, SFC_AUX_OFS, 32'(i % 2));
      bus(1'b1, SFC_CTRL_OFS, 32'(32'h8000 + (i/2%2)*64 + (i/4)*32));
      repeat (4) @(posedge clk);
      chk("sck drive", 32'(i/4), 32'(pins.sck_oe));
      chk("sdo drive", 32'h1, 32'(pins.sdo_oe));
      if (i >= 4) chk("sck idle", 32'(i%4 != 0), 32'(pins.sck_o));
    end
    bus(1'b1, SFC_CTRL_OFS, 32'h0000_8080);
    repeat (2) @(posedge clk);
    chk("sdo gated", 32'h0, 32'(pins.sdo_oe));
    bus(1'b1, SFC_AUX_OFS, 32'h0);
    $display("test clock idle done");
    // mid-run reset restarts the group count; reserved codes stay unused
    for (int c = 0; c < 8; c++) begin
      rst();
      bus(1'b1, SFC_CTRL_OFS, 32'h8000_8020 | 32'((c%2) << 29)
          | 32'((c/2%2) << 27) | 32'((c%6) << 24)
          | 32'(c == 3 ? 256 : 0));
      n = 1 << (c%6);
      for (int k = 0; k < 2; k++) begin
        xfer(k % n == 0, c/2%2 == 1, c%2 == 1, 1'b0);
      end
    end
    $display("test frame counts done");
    rst();
    bus(1'b1, SFC_CTRL_OFS, 32'hc000_8020);
    xfer(1'b0, 1'b0, 1'b0, 1'b1);
    $display("test sync input done");
    rst();
    bus(1'b1, SFC_CTRL_OFS, 32'h3000_8020);
    xfer(1'b1, 1'b1, 1'b1, 1'b0);
    $display("test auto select done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : testbench
